// File: burst_read_engine.v
// burst register read frame interpreter for a byte-serial link
// Contract
// (RULE_01) count byte gives words from start address
// (RULE_02) count zero returns exactly one word
// (RULE_03) host sets count one for single read
// (RULE_04) host sets count to registers wanted
// (RULE_05) count at most 255 registers
// (RULE_06) request checksum: sum seven, invert, add 33h
// (RULE_07) response words sent low byte first
// (RULE_08) each group reads next consecutive address
// (RULE_09) response ends with checksum over prior bytes
// (RULE_10) response head FEh, echoed control, length
// (RULE_11) request bytes six, seven only in checksum
// (RULE_12) eight request bytes, lsb first serial
// (RULE_13) control bits 3:2 match chip select pins
`timescale 1ns/10ps
`default_nettype none
`include "burst_read_consts.vh"
module burst_read_engine #(
  parameter ADDR_W = 12,
  parameter DATA_W = 32
) (
  // clock, reset, enable
  input  wire              clock,
  input  wire              rst,
  input  wire              ce,
  // chip address straps
  input  wire              chipSelHiPin,
  input  wire              chipSelLoPin,
  // received bytes from the uart receiver
  input  wire              rxValid,
  input  wire [7:0]        rxByte,
  // bytes to the uart transmitter
  output wire              txValid,
  input  wire              txReady,
  output reg  [7:0]        txByte,
  // register file read port; data must stand while the strobe is high
  output reg               regRdEn,
  output reg  [ADDR_W-1:0] regRdAddr,
  input  wire [DATA_W-1:0] regRdData,
  // status
  output wire              busy,
  output reg               csumError
);
  localparam ST_RX    = 3'h0;
  localparam ST_FETCH = 3'h1;
  localparam ST_WAIT  = 3'h2;
  localparam ST_HEAD  = 3'h3;
  localparam ST_DATA  = 3'h4;
  localparam ST_CSUM  = 3'h5;

  reg  [2:0]        state_r;
  reg  [3:0]        rxIdx_r;
  reg  [7:0]        ctrl_r;
  reg  [7:0]        addrLo_r;
  reg  [7:0]        words_r;
  reg  [7:0]        left_r;
  reg  [1:0]        hdrIdx_r;
  reg  [1:0]        laneIdx_r;
  reg  [DATA_W-1:0] word_r;
  reg               txValid_r;
  wire [7:0]        csum;
  wire              txFire;
  wire              sumClear;
  wire              sumAdd;
  wire [7:0]        sumByte;
  wire              reqOk;
  wire              sumHunt;
  wire [7:0]        csumNext;

  assign txValid = txValid_r;
  assign txFire  = txValid_r & txReady;
  assign busy    = (state_r != ST_RX);

  // the same accumulator serves request check and response build;
  // it restarts after each eighth request byte and after the response checksum,
  // so a stale sum never leaks into the next frame
  assign sumClear = (state_r == ST_RX && rxValid && rxIdx_r == `IDX_CSUM) || // RULE_06
                    (state_r == ST_CSUM && txFire);                            // RULE_09
  // while hunting for the head byte, stray bytes must stay out of the sum
  assign sumHunt  = (rxIdx_r != 4'h0) || (rxByte == `HEAD_BYTE);
  // bytes six and seven are summed like any other and then dropped
  assign sumAdd   = (state_r == ST_RX) ? (rxValid & sumHunt) : (txFire && state_r != ST_CSUM); // RULE_11
  assign sumByte  = (state_r == ST_RX) ? rxByte : txByte;

  frame_checksum u_sum (
    .clock    (clock),
    .rst      (rst),
    .ce       (ce),
    .clear    (sumClear),
    .addValid (sumAdd),
    .addByte  (sumByte),
    .checksum (csum)
  );

  // a frame is accepted only on read code, matching straps and good sum
  assign reqOk = (rxByte == csum) && // RULE_06
                 (ctrl_r[1:0] == `CTRL_READ_CODE) &&
                 (ctrl_r[`CTRL_SEL_HI_BIT] == chipSelHiPin) && // RULE_13
                 (ctrl_r[`CTRL_SEL_LO_BIT] == chipSelLoPin);   // RULE_13

  // main sequencer; a frame without the head byte first is dropped
  always @(posedge clock) begin
    if (rst) begin
      state_r   <= ST_RX;
      rxIdx_r   <= 4'h0;
      ctrl_r    <= 8'h00;
      addrLo_r  <= 8'h00;
      words_r   <= 8'h00;
      left_r    <= 8'h00;
      hdrIdx_r  <= 2'h0;
      laneIdx_r <= 2'h0;
      word_r    <= {DATA_W{1'b0}};
      txValid_r <= 1'b0;
      txByte    <= 8'h00;
      regRdEn   <= 1'b0;
      regRdAddr <= {ADDR_W{1'b0}};
      csumError <= 1'b0;
    end else if (ce) begin
      regRdEn <= 1'b0;
      case (state_r)
        ST_RX: begin
          if (rxValid) begin
            // byte count bounds the frame to eight bytes
            if (rxIdx_r == 4'h0) begin
              rxIdx_r <= (rxByte == `HEAD_BYTE) ? 4'h1 : 4'h0; // RULE_12
            end else if (rxIdx_r == `IDX_CSUM) begin
              rxIdx_r   <= 4'h0;
              csumError <= (rxByte != csum);
              if (reqOk) begin
                state_r   <= ST_FETCH;
                regRdAddr <= {ctrl_r[`ADDR_HI_MSB:`ADDR_HI_LSB], addrLo_r}; // RULE_01
                hdrIdx_r  <= 2'h0;
              end
            end else begin
              rxIdx_r <= rxIdx_r + 4'h1;
              if (rxIdx_r == `IDX_CTRL) begin
                ctrl_r <= rxByte;
              end
              if (rxIdx_r == `IDX_ADDR) begin
                addrLo_r <= rxByte;
              end
              // 8-bit field cannot exceed 255; zero means one word
              if (rxIdx_r == `IDX_COUNT) begin
                words_r <= (rxByte == 8'h00) ? 8'h01 : rxByte; // RULE_02 RULE_05
              end
              // bytes 6 and 7 only feed the checksum RULE_11
            end
          end
        end
        // one strobe per word; txValid stays low meanwhile
        ST_FETCH: begin
          regRdEn <= 1'b1;
          state_r <= ST_WAIT;
        end
        ST_WAIT: begin
          // read data is taken at the edge that sees the strobe high
          word_r    <= regRdData;
          laneIdx_r <= 2'h0;
          if (hdrIdx_r == 2'h0) begin
            left_r    <= words_r;
            state_r   <= ST_HEAD;
            txValid_r <= 1'b1;
            txByte    <= `HEAD_BYTE; // RULE_10
          end else begin
            state_r   <= ST_DATA;
            txValid_r <= 1'b1;
            txByte    <= regRdData[7:0]; // RULE_07
          end
        end
        ST_HEAD: begin
          if (txFire) begin
            hdrIdx_r <= hdrIdx_r + 2'h1;
            if (hdrIdx_r == 2'h0) begin
              txByte <= {ctrl_r[7:2], `CTRL_READ_CODE}; // RULE_10
            end else if (hdrIdx_r == 2'h1) begin
              txByte <= words_r; // RULE_10
            end else begin
              state_r <= ST_DATA;
              txByte  <= word_r[7:0]; // RULE_07
            end
          end
        end
        ST_DATA: begin
          if (txFire) begin
            laneIdx_r <= laneIdx_r + 2'h1;
            if (laneIdx_r == 2'h3) begin
              left_r <= left_r - 8'h01;
              if (left_r == 8'h01) begin
                state_r <= ST_CSUM;
                txByte  <= (~(csumNext)) + `CSUM_CONST; // RULE_09
              end else begin
                // next group reads the following address
                txValid_r <= 1'b0;
                regRdAddr <= regRdAddr + {{(ADDR_W-1){1'b0}}, 1'b1}; // RULE_08
                state_r   <= ST_FETCH;
              end
            end else begin
              txByte <= word_r[8*laneIdx_r+8 +: 8]; // RULE_07
            end
          end
        end
        // hold the checksum until taken, then go back to hunting
        ST_CSUM: begin
          if (txFire) begin
            txValid_r <= 1'b0;
            state_r   <= ST_RX;
          end
        end
        default: begin
          state_r   <= ST_RX;
          txValid_r <= 1'b0;
        end
      endcase
    end
  end

  // sum including the byte leaving now, so the last byte closes the frame
  assign csumNext = (~(csum - `CSUM_CONST)) + txByte;
endmodule
`default_nettype wire

// File: burst_read_consts.vh
// constants for the burst register read frame interpreter
`ifndef BURST_READ_CONSTS_VH
`define BURST_READ_CONSTS_VH
`define HEAD_BYTE        8'hFE
`define CSUM_CONST       8'h33
`define REQ_LEN          4'h8
`define CTRL_READ_CODE   2'h1
`define CTRL_SEL_HI_BIT  3
`define CTRL_SEL_LO_BIT  2
`define ADDR_HI_MSB      7
`define ADDR_HI_LSB      4
`define IDX_CTRL         4'h1
`define IDX_ADDR         4'h2
`define IDX_COUNT        4'h3
`define IDX_CSUM         4'h7
`endif

// File: frame_checksum.v
// running frame checksum: byte sum, inverted, plus constant
`timescale 1ns/10ps
`default_nettype none
`include "burst_read_consts.vh"
module frame_checksum (
  // clock and control
  input  wire       clock,
  input  wire       rst,
  input  wire       ce,
  input  wire       clear,
  // byte to accumulate
  input  wire       addValid,
  input  wire [7:0] addByte,
  // result
  output wire [7:0] checksum
);
  reg [7:0] sum_r;

  // sum wraps modulo 256; clear has priority so a new frame starts clean
  always @(posedge clock) begin
    if (rst) begin
      sum_r <= 8'h00;
    end else if (ce) begin
      if (clear) begin
        sum_r <= 8'h00;
      end else if (addValid) begin
        sum_r <= sum_r + addByte;
      end
    end
  end

  assign checksum = (~sum_r) + `CSUM_CONST; // RULE_06 RULE_09
endmodule
`default_nettype wire

// File: burst_read_engine_props.sv
// assertions on the ports of the burst read frame interpreter
`timescale 1ns/10ps
`default_nettype none
`include "burst_read_consts.vh"
module engine_props #(parameter ADDR_W = 12, parameter DATA_W = 32) (
  // clock, reset and straps
  input wire logic clock, rst, ce, chipSelHiPin, chipSelLoPin,
  // byte links
  input wire logic rxValid, txValid, txReady,
  input wire logic [7:0] rxByte, txByte,
  // read port and status
  input wire logic regRdEn, busy, csumError,
  input wire logic [ADDR_W-1:0] regRdAddr,
  input wire logic [DATA_W-1:0] regRdData
);
  reg [ADDR_W-1:0] lastAddr_r;
  reg              seen_r;
  // last fetch address of the running response; its seen flag is cleared between frames
  always @(posedge clock) begin
    if (rst || (!busy && !regRdEn)) seen_r <= 1'b0;
    else if (regRdEn) seen_r <= 1'b1;
    if (regRdEn) lastAddr_r <= regRdAddr;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_take; txValid && txReady; endsequence
  sequence s_fetch; regRdEn ##[1:2] txValid; endsequence
  a_reset_quiet: assert property ($fell(rst) |-> !txValid && !busy && !regRdEn)
    else $error("outputs active after reset");
  a_head_byte: assert property ($rose(busy) |-> ##[0:4] (txValid && txByte == `HEAD_BYTE))
    else $error("response does not open with head byte");
  a_fetch_then_tx: assert property (regRdEn |-> s_fetch)
    else $error("no byte after register fetch");
  a_read_pulse: assert property (regRdEn |=> !regRdEn)
    else $error("read strobe longer than one cycle");
  a_addr_step: assert property (regRdEn && seen_r |-> regRdAddr == lastAddr_r + 1'b1)
    else $error("fetch address not consecutive");
  a_byte_hold: assert property (txValid && !txReady |=> txValid && $stable(txByte))
    else $error("tx byte changed before taken");
  a_tx_in_frame: assert property (txValid |-> busy)
    else $error("tx byte offered outside a response");
  a_next_byte: assert property (s_take |=> ##[0:2] (txValid || !busy))
    else $error("response stalled after a byte");
  a_csum_hold: assert property (!rxValid |=> $stable(csumError))
    else $error("checksum flag moved without a byte");
endmodule
bind burst_read_engine engine_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) props (.clock(clock), .rst(rst),
  .ce(ce), .chipSelHiPin(chipSelHiPin), .chipSelLoPin(chipSelLoPin), .rxValid(rxValid), .txValid(txValid),
  .txReady(txReady), .rxByte(rxByte), .txByte(txByte), .regRdEn(regRdEn), .busy(busy),
  .csumError(csumError), .regRdAddr(regRdAddr), .regRdData(regRdData));
`default_nettype wire

// File: reg_file_model.sv
// register file stand-in answering the engine's read port
`timescale 1ns/10ps
`default_nettype none
module reg_file_model (
  // read port from the engine
  input  wire logic        clock,
  input  wire logic        regRdEn,
  input  wire logic [11:0] regRdAddr,
  output wire logic [31:0] regRdData
);
  logic [31:0] junk_r = 32'h0;
  // filler toggles every cycle so a sample taken off the strobe cycle is caught
  always @(posedge clock) begin
    junk_r <= ~junk_r;
  end
  // data stands only while the strobe is high, as the engine takes it at that edge
  assign regRdData = regRdEn ? {regRdAddr, ~regRdAddr, 8'h3C} : junk_r;
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the burst read frame interpreter
`timescale 1ns/10ps
`default_nettype none
`include "burst_read_consts.vh"
`define CHK(n, e, g) begin samples_checked++; if ((e) !== (g)) begin errors++; \
  $display("[ERR] %s expected %h seen %h", n, e, g); end end
module tb_top;
  logic clock = 0, rst = 1, rxValid = 0, txReady = 0, selHi = 1, selLo = 0;
  logic [7:0] rxByte = 8'h00, got;
  wire logic [31:0] regRdData;
  wire logic txValid, regRdEn, busy, csumError;
  wire logic [7:0] txByte;
  wire logic [11:0] regRdAddr;
  int errors = 0, samples_checked = 0, cycles = 0;
  integer seed = 32'hdd5f24c8;
  logic [7:0] exq[$];
  burst_read_engine uut (.clock(clock), .rst(rst), .ce(1'b1), .chipSelHiPin(selHi), .chipSelLoPin(selLo),
    .rxValid(rxValid), .rxByte(rxByte), .txValid(txValid), .txReady(txReady), .txByte(txByte),
    .regRdEn(regRdEn), .regRdAddr(regRdAddr), .regRdData(regRdData), .busy(busy), .csumError(csumError));
  reg_file_model regs (.clock(clock), .regRdEn(regRdEn), .regRdAddr(regRdAddr), .regRdData(regRdData));
  always #50 clock = ~clock;
  task report_and_stop;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // random transmitter stalls and a cycle ceiling against hangs
  always @(posedge clock) begin
    #1 txReady = $random(seed);
    cycles++;
    if (cycles > 40000) begin errors++; report_and_stop; end
  end
  // each byte taken must match the oldest expected byte
  always @(posedge clock) if (txValid === 1'b1 && txReady === 1'b1) begin
    if (exq.size() == 0) `CHK("spareByte", 1'b0, 1'b1)
    else begin got = exq.pop_front(); `CHK("txByte", got, txByte) end
  end
  // send one request; skew spoils its checksum
  task automatic frame(input [11:0] a, input [7:0] n, input [1:0] sel, input [7:0] skew);
    logic [7:0] b[8];
    logic [7:0] s;
    logic [31:0] d;
    int w;
    b[0] = `HEAD_BYTE; b[1] = {a[11:8], sel, `CTRL_READ_CODE}; b[2] = a[7:0]; b[3] = n;
    b[4] = $random(seed); b[5] = $random(seed); b[6] = $random(seed); s = 8'h00;
    for (int i = 0; i < 7; i++) s += b[i];
    b[7] = ~s + `CSUM_CONST + skew;
    if (skew == 8'h00 && sel == {selHi, selLo}) begin
      w = (n == 0) ? 1 : n;
      exq.push_back(b[0]); exq.push_back(b[1]); exq.push_back(w[7:0]);
      for (int k = 0; k < w; k++) begin
        d = {a + k[11:0], ~(a + k[11:0]), 8'h3C};
        for (int j = 0; j < 4; j++) exq.push_back(d[8*j +: 8]);
      end
      s = 8'h00;
      foreach (exq[i]) s += exq[i];
      exq.push_back(~s + `CSUM_CONST);
    end
    for (int i = 0; i < 8; i++) begin @(posedge clock); #1 rxValid = 1; rxByte = b[i]; end
    @(posedge clock); #1 rxValid = 0;
    repeat (4) @(posedge clock);
    for (int t = 0; t < 6000 && (exq.size() != 0 || busy !== 1'b0); t++) @(posedge clock);
    #1 `CHK("leftBytes", 0, exq.size())
    `CHK("csumError", skew != 0, csumError)
  endtask
  initial begin
    repeat (12) @(posedge clock);
    #1 rst = 0;
    frame(12'h123, 8'h00, 2'b10, 8'h00);
    frame(12'h456, 8'h01, 2'b10, 8'h00);
    frame(12'hFFE, 8'h03, 2'b10, 8'h00);
    frame(12'h010, 8'h02, 2'b10, 8'h01);
    for (int m = 0; m < 4; m++) frame(12'h200, 8'h02, m[1:0], 8'h00);
    frame(12'($random(seed)), 8'hFF, 2'b10, 8'h00);
    report_and_stop;
  end
endmodule
`default_nettype wire
